/* hw/tmic_consts.svh */
`ifndef TMIC_CONSTS_SVH
`define TMIC_CONSTS_SVH

// register byte offsets
`define TMIC_ADDR_START 8'h00
`define TMIC_ADDR_CTRL0 8'h04
`define TMIC_ADDR_CTRL1 8'h08
`define TMIC_ADDR_PINMODE 8'h0c
`define TMIC_ADDR_EDGE 8'h10
`define TMIC_ADDR_GPIO 8'h14
`define TMIC_ADDR_PINLVL 8'h18
`define TMIC_ADDR_STATUS 8'h1c
`define TMIC_ADDR_MASK 8'h20
`define TMIC_ADDR_CNT0 8'h24
`define TMIC_ADDR_CNT1 8'h28
`define TMIC_ADDR_GR_BASE 8'h40
`define TMIC_ADDR_GR_LAST 8'h5c

// pin mode field positions
`define TMIC_PM_FILT_LSB 8
`define TMIC_PM_OSC_TRIG 16
`define TMIC_PM_EXT_CLK 17
`define TMIC_PM_BUFC_LSB 18
// start register field positions
`define TMIC_ST_STOPEN_LSB 2

// count source codes
`define TMIC_CKS_DIV1 3'h0
`define TMIC_CKS_DIV2 3'h1
`define TMIC_CKS_DIV4 3'h2
`define TMIC_CKS_DIV8 3'h3
`define TMIC_CKS_DIV32 3'h4
`define TMIC_CKS_EXT 3'h5
`define TMIC_CKS_OSC40 3'h6

// counter clear codes
`define TMIC_CLR_FREE 3'h0
`define TMIC_CLR_CAP_A 3'h1
`define TMIC_CLR_CAP_B 3'h2
`define TMIC_CLR_CAP_C 3'h5
`define TMIC_CLR_CAP_D 3'h6

// edge select codes
`define TMIC_EDGE_RISE 2'h0
`define TMIC_EDGE_FALL 2'h1

// counter limits and reset values
`define TMIC_COUNT_MAX 16'hffff
`define TMIC_COUNT_CLEAR 16'h0000
`define TMIC_REG_RESET 32'h0000_0000

`endif

/* hw/tmic_pkg.sv */
package tmic_pkg;

    // per-channel timer control word
    typedef struct packed {
        logic [2:0] clear_sel;
        logic [1:0] ext_edge;
        logic [2:0] clk_sel;
    } tmic_ctrl_type;

    // conditioned pin: accepted level and one-cycle edge pulses
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } tmic_pin_type;

    // latched ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } tmic_ahb_req_type;

endpackage

/* hw/tmic_pin_cond.sv */
`timescale 1ns/1ns
module tmic_pin_cond
    import tmic_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic pin_in,
    input wire logic filter_en_in,
    output tmic_pin_type pin_out
);

    logic sync1;
    logic sync2;
    logic sync3;
    logic sync4;
    logic level;
    logic next_level;

    // ----------------------------------------
    // synchroniser and level acceptance
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            sync4 <= 1'b0;
        end else if (ce_in) begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            sync4 <= sync3;
        end
    end

    // filter adds a third agreeing sample before a level is taken
    always_comb begin
        next_level = level;
        if (sync2 == sync3 && (!filter_en_in || sync3 == sync4)) begin
            next_level = sync3;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level <= 1'b0;
            pin_out <= '0;
        end else if (ce_in) begin
            level <= next_level;
            pin_out.level <= next_level;
            pin_out.rise <= next_level & ~level;
            pin_out.fall <= ~next_level & level;
        end
    end

endmodule

/* hw/tmic_channel.sv */
`timescale 1ns/1ns
`include "tmic_consts.svh"
module tmic_channel
    import tmic_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic [2:0] clear_sel_in,
    input wire logic [3:0] cap_in,
    input wire logic buf_en_c_in,
    input wire logic load_in,
    input wire logic [15:0] load_value_in,
    output logic [15:0] count_out,
    output logic [63:0] gr_out,
    output logic ovf_out
);

    logic clear_hit;
    logic count_step;

    always_comb begin
        case (clear_sel_in)
            `TMIC_CLR_CAP_A: clear_hit = cap_in[0];
            `TMIC_CLR_CAP_B: clear_hit = cap_in[1];
            `TMIC_CLR_CAP_C: clear_hit = cap_in[2];
            `TMIC_CLR_CAP_D: clear_hit = cap_in[3];
            default: clear_hit = 1'b0;
        endcase
    end

    assign count_step = run_in & tick_in;

    // ----------------------------------------
    // up-counter
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_out <= `TMIC_COUNT_CLEAR;
            ovf_out <= 1'b0;
        end else if (ce_in) begin
            ovf_out <= count_step & ~load_in & ~(run_in & clear_hit)
                & (count_out == `TMIC_COUNT_MAX);
            if (load_in) begin
                count_out <= load_value_in;
            end else if (run_in && clear_hit) begin
                count_out <= `TMIC_COUNT_CLEAR;
            end else if (count_step) begin
                count_out <= count_out + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // general registers a..d
    // ----------------------------------------
    for (genvar j = 0; j < 4; j++) begin : g_gr
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                gr_out[j*16 +: 16] <= `TMIC_COUNT_CLEAR;
            end else if (ce_in) begin
                if (j == 2 && buf_en_c_in) begin
                    if (cap_in[0]) begin
                        gr_out[j*16 +: 16] <= gr_out[15:0];
                    end
                end else if (cap_in[j]) begin
                    gr_out[j*16 +: 16] <= count_out;
                end
            end
        end
    end

endmodule

/* hw/tmic_top.sv */
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "tmic_consts.svh"
module tmic_top
    import tmic_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic [7:0] CAPTURE_PIN_IN,
    output logic [7:0] CAPTURE_PIN_OUT,
    output logic [7:0] CAPTURE_PIN_OE_OUT,
    input wire logic OSC_DIV128_TRIGGER_IN,
    input wire logic FAST_OSC_40M_IN,
    output logic IRQ_OUT
);

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [1:0] count_start;
    logic [1:0] stop_enable;
    tmic_ctrl_type ctrl [2];
    logic [7:0] cap_enable;
    logic [7:0] filter_enable;
    logic osc_trigger_sel;
    logic ext_clock_sel;
    logic [1:0] buffer_enable_c;
    logic [15:0] edge_sel;
    logic [7:0] gpio_value;
    logic [7:0] gpio_enable;
    logic [9:0] status;
    logic [9:0] mask;

    tmic_ahb_req_type req;
    logic addr_phase;
    logic wr_now;
    logic [31:0] read_word;

    tmic_pin_type pin_cond [8];
    tmic_pin_type osc128;
    tmic_pin_type osc40;
    logic [7:0] cap_evt;
    logic [7:0] chan_cap;
    logic [4:0] prescale;
    logic [1:0] tick;
    logic [1:0] ovf;
    logic [1:0] load;
    logic [15:0] count [2];
    logic [63:0] gr [2];
    logic [9:0] next_status;
    logic ext_tick;

    // ----------------------------------------
    // input conditioning
    // ----------------------------------------
    for (genvar p = 0; p < 8; p++) begin : g_pin
        tmic_pin_cond u_pin (
            .clk_in(REF_CLK_IN),
            .rst_n_in(RST_N_IN),
            .ce_in(CE_IN),
            .pin_in(CAPTURE_PIN_IN[p]),
            .filter_en_in(filter_enable[p]),
            .pin_out(pin_cond[p])
        );
    end

    tmic_pin_cond u_osc128 (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .pin_in(OSC_DIV128_TRIGGER_IN),
        .filter_en_in(1'b0),
        .pin_out(osc128)
    );

    // a 40 MHz source sampled at 50 MHz: ticks are counted but can merge
    tmic_pin_cond u_osc40 (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .pin_in(FAST_OSC_40M_IN),
        .filter_en_in(1'b0),
        .pin_out(osc40)
    );

    // ----------------------------------------
    // capture events
    // ----------------------------------------
    function automatic logic edge_hit(input tmic_pin_type pin, input logic [1:0] sel);
        logic hit;
        case (sel)
            `TMIC_EDGE_RISE: hit = pin.rise;
            `TMIC_EDGE_FALL: hit = pin.fall;
            default: hit = pin.rise | pin.fall;
        endcase
        return hit;
    endfunction

    always_comb begin
        for (int p = 0; p < 8; p++) begin
            cap_evt[p] = cap_enable[p] & edge_hit(pin_cond[p], edge_sel[p*2 +: 2]);
        end
        cap_evt[0] = ~ext_clock_sel & cap_enable[0]
            & edge_hit(pin_cond[0], edge_sel[1:0]);
        chan_cap = cap_evt;
        if (osc_trigger_sel) begin
            chan_cap[0] = osc128.rise;
        end
    end

    // ----------------------------------------
    // count source selection
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            prescale <= 5'h00;
        end else if (CE_IN) begin
            prescale <= prescale + 5'h01;
        end
    end

    assign ext_tick = ext_clock_sel & edge_hit(pin_cond[0], ctrl[0].ext_edge);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            case (ctrl[i].clk_sel)
                `TMIC_CKS_DIV1: tick[i] = 1'b1;
                `TMIC_CKS_DIV2: tick[i] = prescale[0];
                `TMIC_CKS_DIV4: tick[i] = &prescale[1:0];
                `TMIC_CKS_DIV8: tick[i] = &prescale[2:0];
                `TMIC_CKS_DIV32: tick[i] = &prescale[4:0];
                `TMIC_CKS_EXT: tick[i] = ext_tick;
                `TMIC_CKS_OSC40: tick[i] = osc40.rise;
                default: tick[i] = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // timer channels
    // ----------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        tmic_channel u_chan (
            .clk_in(REF_CLK_IN),
            .rst_n_in(RST_N_IN),
            .ce_in(CE_IN),
            .tick_in(tick[i]),
            .run_in(count_start[i]),
            .clear_sel_in(ctrl[i].clear_sel),
            .cap_in(chan_cap[i*4 +: 4]),
            .buf_en_c_in(buffer_enable_c[i]),
            .load_in(load[i]),
            .load_value_in(HWDATA_IN[15:0]),
            .count_out(count[i]),
            .gr_out(gr[i]),
            .ovf_out(ovf[i])
        );
    end

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    assign addr_phase = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    assign wr_now = req.valid & req.write;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            load[i] = wr_now && req.addr == (i == 0 ? `TMIC_ADDR_CNT0 : `TMIC_ADDR_CNT1);
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            req <= '0;
        end else if (CE_IN) begin
            if (HREADY_IN) begin
                req.valid <= addr_phase;
                req.write <= HWRITE_IN;
                req.addr <= HADDR_IN[7:0];
            end
        end
    end

    always_comb begin
        read_word = `TMIC_REG_RESET;
        case (HADDR_IN[7:0])
            `TMIC_ADDR_START: read_word[3:0] = {stop_enable, count_start};
            `TMIC_ADDR_CTRL0: read_word[7:0] = ctrl[0];
            `TMIC_ADDR_CTRL1: read_word[7:0] = ctrl[1];
            `TMIC_ADDR_PINMODE: read_word[19:0] = {buffer_enable_c, ext_clock_sel,
                osc_trigger_sel, filter_enable, cap_enable};
            `TMIC_ADDR_EDGE: read_word[15:0] = edge_sel;
            `TMIC_ADDR_GPIO: read_word[15:0] = {gpio_enable, gpio_value};
            `TMIC_ADDR_PINLVL: begin
                for (int p = 0; p < 8; p++) begin
                    read_word[p] = pin_cond[p].level;
                end
            end
            `TMIC_ADDR_STATUS: read_word[9:0] = status;
            `TMIC_ADDR_MASK: read_word[9:0] = mask;
            `TMIC_ADDR_CNT0: read_word[15:0] = count[0];
            `TMIC_ADDR_CNT1: read_word[15:0] = count[1];
            default: begin
                if (HADDR_IN[7:0] >= `TMIC_ADDR_GR_BASE && HADDR_IN[7:0] <= `TMIC_ADDR_GR_LAST) begin
                    read_word[15:0] = HADDR_IN[4] ? gr[1][HADDR_IN[3:2]*16 +: 16]
                                                  : gr[0][HADDR_IN[3:2]*16 +: 16];
                end
            end
        endcase
    end

    // read data is taken in the address phase and shown in the data phase
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            HRDATA_OUT <= `TMIC_REG_RESET;
        end else if (CE_IN) begin
            if (addr_phase && !HWRITE_IN) begin
                HRDATA_OUT <= read_word;
            end
        end
    end

    // ----------------------------------------
    // start and stop control
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            count_start <= 2'h0;
            stop_enable <= 2'h0;
        end else if (CE_IN) begin
            if (wr_now && req.addr == `TMIC_ADDR_START) begin
                stop_enable <= HWDATA_IN[`TMIC_ST_STOPEN_LSB +: 2];
                for (int i = 0; i < 2; i++) begin
                    if (HWDATA_IN[i]) begin
                        count_start[i] <= 1'b1;
                    end else if (HWDATA_IN[`TMIC_ST_STOPEN_LSB + i]) begin
                        count_start[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl[0] <= '0;
            ctrl[1] <= '0;
            cap_enable <= 8'h00;
            filter_enable <= 8'h00;
            osc_trigger_sel <= 1'b0;
            ext_clock_sel <= 1'b0;
            buffer_enable_c <= 2'h0;
            edge_sel <= 16'h0000;
            gpio_value <= 8'h00;
            gpio_enable <= 8'h00;
            mask <= 10'h000;
        end else if (CE_IN && wr_now) begin
            case (req.addr)
                `TMIC_ADDR_CTRL0: ctrl[0] <= HWDATA_IN[7:0];
                `TMIC_ADDR_CTRL1: ctrl[1] <= HWDATA_IN[7:0];
                `TMIC_ADDR_PINMODE: begin
                    cap_enable <= HWDATA_IN[7:0];
                    filter_enable <= HWDATA_IN[`TMIC_PM_FILT_LSB +: 8];
                    osc_trigger_sel <= HWDATA_IN[`TMIC_PM_OSC_TRIG];
                    ext_clock_sel <= HWDATA_IN[`TMIC_PM_EXT_CLK];
                    buffer_enable_c <= HWDATA_IN[`TMIC_PM_BUFC_LSB +: 2];
                end
                `TMIC_ADDR_EDGE: edge_sel <= HWDATA_IN[15:0];
                `TMIC_ADDR_GPIO: begin
                    gpio_value <= HWDATA_IN[7:0];
                    gpio_enable <= HWDATA_IN[15:8];
                end
                `TMIC_ADDR_MASK: mask <= HWDATA_IN[9:0];
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // general port drive
    // ----------------------------------------
    // a pin in capture or count-clock use is never driven
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            CAPTURE_PIN_OUT <= 8'h00;
            CAPTURE_PIN_OE_OUT <= 8'h00;
        end else if (CE_IN) begin
            CAPTURE_PIN_OUT <= gpio_value;
            CAPTURE_PIN_OE_OUT <= gpio_enable & ~cap_enable
                & ~{7'h00, ext_clock_sel};
        end
    end

    // ----------------------------------------
    // status flags and interrupt
    // ----------------------------------------
    // a new event in the clearing cycle keeps its flag
    always_comb begin
        next_status = status;
        if (wr_now && req.addr == `TMIC_ADDR_STATUS) begin
            next_status = status & ~HWDATA_IN[9:0];
        end
        next_status = next_status | {ovf, chan_cap};
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            status <= 10'h000;
        end else if (CE_IN) begin
            status <= next_status;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            IRQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            IRQ_OUT <= |(next_status & mask);
        end
    end

endmodule

/* test/tmic_monitor.sv */
`timescale 1ns/1ns
`include "tmic_consts.svh"
module tmic_monitor (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic [7:0] CAPTURE_PIN_OUT,
    input wire logic [7:0] CAPTURE_PIN_OE_OUT,
    input wire logic IRQ_OUT
);
    // ----------------------------------------
    // shadows of the written config
    // ----------------------------------------
    logic take, wr_pend, unmapped;
    logic [7:0] wr_addr;
    logic [15:0] gpio_sh;
    logic [17:0] pmode_sh;
    logic [9:0] mask_sh;
    assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN && CE_IN;
    assign unmapped = (HADDR_IN[7:0] > `TMIC_ADDR_CNT1 && HADDR_IN[7:0] < `TMIC_ADDR_GR_BASE)
        || HADDR_IN[7:0] > `TMIC_ADDR_GR_LAST;
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            gpio_sh <= 16'h0000;
            pmode_sh <= 18'h00000;
            mask_sh <= 10'h000;
        end else if (CE_IN) begin
            wr_pend <= take && HWRITE_IN;
            wr_addr <= HADDR_IN[7:0];
            if (wr_pend && wr_addr == `TMIC_ADDR_GPIO) begin
                gpio_sh <= HWDATA_IN[15:0];
            end
            if (wr_pend && wr_addr == `TMIC_ADDR_PINMODE) begin
                pmode_sh <= HWDATA_IN[17:0];
            end
            if (wr_pend && wr_addr == `TMIC_ADDR_MASK) begin
                mask_sh <= HWDATA_IN[9:0];
            end
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence s_rd_take;
        take && !HWRITE_IN;
    endsequence
    sequence s_cfg_settled;
        ($stable(gpio_sh) && $stable(pmode_sh)) [*3];
    endsequence
    chk_ready_high: assert property (HREADYOUT_OUT)
        else $error("slave not ready");
    chk_resp_okay: assert property (!HRESP_OUT)
        else $error("slave response not okay");
    chk_unmapped_zero: assert property (s_rd_take and unmapped |=> HRDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    chk_upper_zero: assert property (s_rd_take |=> HRDATA_OUT[31:20] == 12'h000)
        else $error("read data upper bits set");
    chk_rdata_hold: assert property (!(take && !HWRITE_IN) |=> $stable(HRDATA_OUT))
        else $error("read data changed without read");
    chk_irq_masked: assert property (mask_sh == 10'h000 [*2] |-> !IRQ_OUT)
        else $error("interrupt with all sources masked");
    chk_irq_cause: assert property ($rose(IRQ_OUT) |-> $past(mask_sh) != 10'h000)
        else $error("interrupt rose without enabled source");
    chk_pin_value: assert property (s_cfg_settled |-> CAPTURE_PIN_OUT == gpio_sh[7:0])
        else $error("pin output value wrong");
    chk_pin_enable: assert property (s_cfg_settled |-> CAPTURE_PIN_OE_OUT ==
        (gpio_sh[15:8] & ~pmode_sh[7:0] & ~{7'h00, pmode_sh[17]}))
        else $error("pin output enable wrong");
    chk_freeze_hold: assert property (!CE_IN |=> $stable(HRDATA_OUT) && $stable(IRQ_OUT))
        else $error("outputs moved while clock enable low");
endmodule
bind tmic_top tmic_monitor tmic_monitor_i (
    .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .CAPTURE_PIN_OUT(CAPTURE_PIN_OUT),
    .CAPTURE_PIN_OE_OUT(CAPTURE_PIN_OE_OUT), .IRQ_OUT(IRQ_OUT)
);

/* test/tmic_sig_src.sv */
`timescale 1ns/1ns
module tmic_sig_src (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [7:0] level_in,
    input wire logic trig_in,
    output logic [7:0] pin_out,
    output logic trig_out,
    output logic fosc_out
);
    // ----------------------------------------
    // pin source, prompt or two cycles late
    // ----------------------------------------
    logic [7:0] lag1, lag2;
    always_ff @(posedge clk_in) begin
        lag1 <= level_in;
        lag2 <= lag1;
    end
    assign pin_out = slow_in ? lag2 : level_in;
    assign trig_out = trig_in;
    // free-running fast oscillator, close to 40 MHz
    initial begin
        fosc_out = 1'b0;
        forever #12 fosc_out = ~fosc_out;
    end
endmodule

/* test/tb_tmic_top.sv */
`timescale 1ns/1ns
`include "tmic_consts.svh"
module tb_tmic_top;
    logic clk, rst_n, ce, hsel, hwrite, trig, slow, hready, hresp, irq, fosc, trig_w;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] lvl, src_pin, pin_o, pin_oe, pin_w;
    int error_cnt, comparisons;
    // pins driven by the block win over the source
    assign pin_w = (pin_oe & pin_o) | (~pin_oe & src_pin);
    tmic_top tmic_top_i (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .CAPTURE_PIN_IN(pin_w), .CAPTURE_PIN_OUT(pin_o),
        .CAPTURE_PIN_OE_OUT(pin_oe), .OSC_DIV128_TRIGGER_IN(trig_w), .FAST_OSC_40M_IN(fosc),
        .IRQ_OUT(irq));
    tmic_sig_src tmic_sig_src_i (.clk_in(clk), .slow_in(slow), .level_in(lvl), .trig_in(trig),
        .pin_out(src_pin), .trig_out(trig_w), .fosc_out(fosc));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) begin
            error_cnt++;
            end_sim();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        cmp32(r, exp);
    endtask
    task automatic pin_set(input logic [7:0] v);
        lvl <= v;
        idle(10);
    endtask
    // ----------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #1000000;
        error_cnt++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        lvl = 8'h00;
        trig = 1'b0;
        slow = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        idle(16);
        rst_n <= 1'b1;
        idle(1);
        rd_chk(`TMIC_ADDR_START, 32'h0);
        rd_chk(`TMIC_ADDR_STATUS, 32'h0);
        rd_chk(8'h30, 32'h0);
        wr(`TMIC_ADDR_PINMODE, 32'h0002_00f0);
        wr(`TMIC_ADDR_GPIO, 32'h0000_ff5a);
        idle(3);
        cmp32({24'h0, pin_oe}, 32'h0000_000e);
        cmp32({24'h0, pin_o}, 32'h0000_005a);
        // channel 1 pins: rise, fall, both, both
        wr(`TMIC_ADDR_EDGE, 32'h0000_e400);
        wr(`TMIC_ADDR_CNT1, 32'h0000_0111);
        pin_set(8'hf0);
        rd_chk(`TMIC_ADDR_STATUS, 32'h0000_00d0);
        wr(`TMIC_ADDR_CNT1, 32'h0000_0222);
        pin_set(8'h00);
        rd_chk(`TMIC_ADDR_STATUS, 32'h0000_00f0);
        rd_chk(8'h50, 32'h0000_0111);
        for (int i = 1; i < 4; i++) begin
            rd_chk(8'h50 + 8'(4 * i), 32'h0000_0222);
        end
        wr(`TMIC_ADDR_STATUS, 32'h0000_0030);
        rd_chk(`TMIC_ADDR_STATUS, 32'h0000_00c0);
        wr(`TMIC_ADDR_MASK, 32'h0000_0040);
        idle(2);
        cmp32({31'h0, irq}, 32'h1);
        wr(`TMIC_ADDR_STATUS, 32'h0000_00c0);
        idle(2);
        cmp32({31'h0, irq}, 32'h0);
        // overflow, with a start-bit zero write that must not stop
        wr(`TMIC_ADDR_MASK, 32'h0000_0100);
        wr(`TMIC_ADDR_CNT0, 32'h0000_ffe0);
        wr(`TMIC_ADDR_START, 32'h0000_0001);
        wr(`TMIC_ADDR_START, 32'h0000_0000);
        rd_chk(`TMIC_ADDR_START, 32'h0000_0001);
        idle(40);
        rd_chk(`TMIC_ADDR_STATUS, 32'h0000_0100);
        cmp32({31'h0, irq}, 32'h1);
        wr(`TMIC_ADDR_START, 32'h0000_0004);
        wr(`TMIC_ADDR_STATUS, 32'h0000_0100);
        wr(`TMIC_ADDR_CNT0, 32'h0000_0055);
        idle(10);
        rd_chk(`TMIC_ADDR_CNT0, 32'h0000_0055);
        cmp32({31'h0, irq}, 32'h0);
        // buffered capture on channel 0 register a, late source
        slow <= 1'b1;
        wr(`TMIC_ADDR_PINMODE, 32'h0004_0001);
        wr(`TMIC_ADDR_CNT0, 32'h0000_0011);
        pin_set(8'h01);
        wr(`TMIC_ADDR_CNT0, 32'h0000_0022);
        pin_set(8'h00);
        pin_set(8'h01);
        rd_chk(`TMIC_ADDR_GR_BASE, 32'h0000_0022);
        rd_chk(8'h48, 32'h0000_0011);
        slow <= 1'b0;
        // oscillator trigger replaces the pin for register a
        wr(`TMIC_ADDR_PINMODE, 32'h0001_0001);
        wr(`TMIC_ADDR_CNT0, 32'h0000_0033);
        trig <= 1'b1;
        idle(10);
        trig <= 1'b0;
        rd_chk(`TMIC_ADDR_GR_BASE, 32'h0000_0033);
        wr(`TMIC_ADDR_CNT0, 32'h0000_0044);
        pin_set(8'h00);
        pin_set(8'h01);
        rd_chk(`TMIC_ADDR_GR_BASE, 32'h0000_0033);
        // pin a0 as count clock, cleared on capture a
        wr(`TMIC_ADDR_PINMODE, 32'h0003_0000);
        wr(`TMIC_ADDR_CTRL0, 32'h0000_0025);
        wr(`TMIC_ADDR_START, 32'h0000_0001);
        pin_set(8'h00);
        pin_set(8'h01);
        rd_chk(`TMIC_ADDR_CNT0, 32'h0000_0045);
        trig <= 1'b1;
        idle(10);
        rd_chk(`TMIC_ADDR_CNT0, 32'h0000_0000);
        rd_chk(`TMIC_ADDR_GR_BASE, 32'h0000_0045);
        ce <= 1'b0;
        idle(4);
        ce <= 1'b1;
        idle(2);
        end_sim();
    end
endmodule
